// file: bench/tsw_block_asserts.sv
/*
  port assertions for tsw_block.
  assumes binding to tsw_block; one clock domain.
*/
module tsw_block_asserts (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 trigger,
  input wire tsw_pkg::tsw_packet_t packet
);
  import tsw_pkg::*;
  logic        seen;
  logic [31:0] last_cnt;
  logic [31:0] last_ts;
  // last packet seen, for step checks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen     <= 1'b0;
      last_cnt <= 32'h0;
      last_ts  <= 32'h0;
    end else if (packet.valid) begin
      seen     <= 1'b1;
      last_cnt <= packet.accept_count;
      last_ts  <= packet.timestamp;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("no ready after setup");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("ready outside access");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held");
  property p_err_zero;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("bad error response");
  property p_valid_cause;
    packet.valid |-> $past(trigger);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("packet without trigger");
  property p_reserved;
    packet.valid |-> !packet.status[2] && packet.status[15:14] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bit set");
  property p_count_step;
    packet.valid && seen |-> packet.accept_count == last_cnt + 32'h1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("accept count step");
  property p_ts_order;
    packet.valid && seen && last_ts != 32'h0 && packet.timestamp != 32'h0
      |-> packet.timestamp >= last_ts;
  endproperty
  a_ts_order: assert property (p_ts_order)
    else $error("timestamp went back");
endmodule

// file: bench/tsw_block_tb_top.sv
/*
  self-checking bench for tsw_block: registers, timestamp, lost trigger,
  interrupt, status layouts.
  assumes the package and constants header are visible.
*/
`include "tsw_consts.svh"
module tsw_block_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tsw_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trigger;
  logic        position_valid;
  tsw_events_t events;
  tsw_levels_t levels_async;
  tsw_packet_t packet;
  tsw_packet_t pk;
  tsw_events_t ev;
  tsw_levels_t lv;
  logic        irq;
  logic        e;
  logic [31:0] r;
  logic [31:0] ta;
  logic [31:0] tb;
  logic [31:0] cnt;
  logic [31:0] pv;
  int          err_total;
  int          checks_done;
  int          cyc = 0;
  int          seed;
  int          t0;
  int          i;
  tsw_block dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger(trigger), .position_valid(position_valid), .events(events),
    .levels_async(levels_async), .packet(packet), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16 && pready !== 1'b1; n++) begin
      @(posedge clk);
    end
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic trig(input logic acc);
    trigger <= 1'b1;
    @(posedge clk);
    trigger <= 1'b0;
    @(posedge clk);
    pk = packet;
    chk({31'h0, pk.valid}, {31'h0, acc});
    if (acc) begin
      cnt++;
      chk(pk.accept_count, cnt);
    end
  endtask
  function automatic logic [15:0] exp_sw(int p, tsw_events_t v,
                                         tsw_levels_t l, logic ok);
    logic [15:0] s;
    s = 16'h0;
    s[1] = (p == 0 || p == 3) ? v.amp_low : v.crc_err;
    if (p != 2) begin
      s[0] = ok;
      s[4] = v.power_err;
      s[5] = v.fan_err;
    end
    if (p == 0 || p == 3) begin
      s[3] = v.freq_exceeded;
      s[8] = v.ref1_saved;
    end
    if (p == 0) begin
      s[13:9] = {l.limit, l.homing, v.coded_err, v.coded_ok, v.ref2_saved};
    end
    if (p == 1) begin
      s[9:8] = {v.err_msg2, v.err_msg1};
    end
    if (p == 2) begin
      s[12:5] = {l.warning, l.refmark, l.busy, l.content};
    end
    return s;
  endfunction
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h407f;
    cnt = 32'h0;
    err_total = 0;
    checks_done = 0;
    reset_n = 1'b0;
    {psel, penable, pwrite, trigger, position_valid} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    events = '0;
    levels_async = '0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk(`TSW_OFF_TICKS_US, 32'h14);
    apb(1'b1, `TSW_OFF_TICKS_US, 32'h3);
    rd_chk(`TSW_OFF_TICKS_US, 32'h14);
    rd_chk(`TSW_OFF_PERIOD, 32'h14);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // interval of 0.25 us at 20 ticks per us
    apb(1'b1, `TSW_OFF_PERIOD, 32'h5);
    apb(1'b1, `TSW_OFF_CTRL, 32'h1);
    apb(1'b1, `TSW_OFF_IRQ_MASK, 32'h1);
    t0 = cyc;
    trig(1'b1);
    apb(1'b0, `TSW_OFF_TIMESTAMP, 32'h0);
    ta = r;
    while (cyc < t0 + 200) @(posedge clk);
    trig(1'b1);
    apb(1'b0, `TSW_OFF_TIMESTAMP, 32'h0);
    tb = r;
    chk(tb - ta, 32'h28);
    trig(1'b0);
    rd_chk(`TSW_OFF_TIMESTAMP, tb);
    rd_chk(`TSW_OFF_ACCEPT_CNT, cnt);
    chk({31'h0, irq}, 32'h1);
    repeat (45) @(posedge clk);
    trig(1'b1);
    apb(1'b0, `TSW_OFF_STATUS, 32'h0);
    chk(r & 32'h80, 32'h80);
    apb(1'b1, `TSW_OFF_CLEAR, 32'h800);
    apb(1'b1, `TSW_OFF_IRQ_STATUS, 32'h7);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `TSW_OFF_STATUS, 32'h0);
    chk(r & 32'h80, 32'h0);
    apb(1'b1, `TSW_OFF_IRQ_MASK, 32'h0);
    for (i = 0; i < 12; i++) begin
      ev = tsw_events_t'($random(seed));
      lv = tsw_levels_t'($random(seed));
      pv = $random(seed);
      apb(1'b1, `TSW_OFF_CTRL, {31'h0, i[2]});
      apb(1'b1, `TSW_OFF_POLL_TYPE, i % 4);
      apb(1'b1, `TSW_OFF_CLEAR, 32'hFFF);
      position_valid <= pv[0];
      levels_async <= lv;
      events <= ev;
      @(posedge clk);
      events <= '0;
      repeat (45) @(posedge clk);
      trig(1'b1);
      apb(1'b0, `TSW_OFF_TIMESTAMP, 32'h0);
      ta = r;
      chk(pk.timestamp, i[2] ? ta : 32'h0);
      chk({16'h0, pk.status}, {16'h0, exp_sw(i % 4, ev, lv, pv[0])});
      rd_chk(`TSW_OFF_STATUS, {16'h0, exp_sw(i % 4, ev, lv, pv[0])});
      chk({31'h0, irq}, 32'h0);
    end
    tally_and_finish();
  end
endmodule
bind tsw_block tsw_block_asserts u_chk (.clk(clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .trigger(trigger), .packet(packet));

// file: rtl/tsw_block.sv
/*
  trigger timestamp and per-channel status word, one axis, with apb slave.
  assumes triggers and encoder events are pulses on clk; levels may be
  asynchronous and are synchronised here.
*/
//
// Overview of operation
// - free-running timestamp counter, programmable tick
// - accepted trigger captures timestamp counter
// - enabled timestamp goes out with packet
// - tick is period value of clocks
// - readable constant gives clock ticks per microsecond
// - one status word per channel, independent of timestamp enable
// - status layout follows the poll type
// - bit0 valid except datum, bit1 amplitude or crc, 8-9 messages
// - bit3 frequency exceeded, reserved for serial and datum
// - bits 4,5,7 power, fan, lost trigger, except datum
// - incremental ref bits 8-11, auxiliary bit 8
// - bits 12,13 homing and limit at poll
// - datum: content bits 5-9, flags 10-12
// - error flags sticky until clear command
// - too-early trigger sets lost-trigger flag
`include "tsw_consts.svh"
module tsw_block #(
  parameter int unsigned TICKS_PER_US = `TSW_CLK_MHZ
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 trigger,
  input  wire logic                 position_valid,
  input  wire tsw_pkg::tsw_events_t events,
  input  wire tsw_pkg::tsw_levels_t levels_async,
  output tsw_pkg::tsw_packet_t      packet,
  output logic                      irq
);
  import tsw_pkg::*;

  // refuse a ticks value that the 16-bit read field cannot carry
  if (TICKS_PER_US == 0 || TICKS_PER_US > 65535) begin : g_bad_ticks
    $error("TICKS_PER_US out of range");
  end

  localparam logic [15:0] TICKS_US = 16'(TICKS_PER_US);
  localparam logic [31:0] MIN_GAP_RESET = 32'(`TSW_MIN_GAP_CYCLES);

  typedef struct packed {
    logic [31:0] period;
    logic [31:0] tick_cnt;
    logic [31:0] ts_counter;
    logic [31:0] timestamp;
    logic [31:0] min_gap;
    logic [31:0] gap_cnt;
    logic [31:0] accept_cnt;
    logic        ts_enable;
    tsw_poll_t   poll_type;
    tsw_events_t sticky;
    logic        lost;
    tsw_levels_t lv_meta;
    tsw_levels_t lv_sync;
    tsw_levels_t lv_poll;
    logic [`TSW_IRQ_BITS-1:0] irq_status;
    logic [`TSW_IRQ_BITS-1:0] irq_mask;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    tsw_packet_t packet;
    logic        irq;
  } tsw_state_t;

  tsw_state_t st;
  tsw_state_t next_st;

  logic [15:0] status_word;
  logic        accepted;
  logic        too_early;
  logic        wr_access;
  logic        rd_access;
  logic [31:0] wdat;
  logic        err_any;
  tsw_levels_t poll_lv;

  //////////////////////////////////////////////////////////////////////////
  // status word assembly
  always_comb begin
    // levels as latched by the poll in progress, so the packet sees them
    poll_lv     = accepted ? st.lv_sync : st.lv_poll;
    status_word = 16'h0000;
    case (st.poll_type)
      TSW_POLL_INCR, TSW_POLL_AUX: begin
        status_word[`TSW_B_VALID]   = position_valid;
        status_word[`TSW_B_AMP_CRC] = st.sticky.amp_low;
        status_word[`TSW_B_FREQ]    = st.sticky.freq_exceeded;
        status_word[`TSW_B_POWER]   = st.sticky.power_err;
        status_word[`TSW_B_FAN]     = st.sticky.fan_err;
        status_word[`TSW_B_LOST]    = st.lost;
        status_word[`TSW_B_REF1]    = st.sticky.ref1_saved;
        if (st.poll_type == TSW_POLL_INCR) begin
          status_word[`TSW_B_REF2]      = st.sticky.ref2_saved;
          status_word[`TSW_B_CODED_OK]  = st.sticky.coded_ok;
          status_word[`TSW_B_CODED_ERR] = st.sticky.coded_err;
          status_word[`TSW_B_HOMING]    = poll_lv.homing;
          status_word[`TSW_B_LIMIT]     = poll_lv.limit;
        end
      end
      TSW_POLL_SERPOS: begin
        status_word[`TSW_B_VALID]   = position_valid;
        status_word[`TSW_B_AMP_CRC] = st.sticky.crc_err;
        status_word[`TSW_B_POWER]   = st.sticky.power_err;
        status_word[`TSW_B_FAN]     = st.sticky.fan_err;
        status_word[`TSW_B_LOST]    = st.lost;
        status_word[`TSW_B_REF1]    = st.sticky.err_msg1;
        status_word[`TSW_B_REF2]    = st.sticky.err_msg2;
      end
      TSW_POLL_DATUM: begin
        status_word[`TSW_B_AMP_CRC] = st.sticky.crc_err;
        status_word[`TSW_B_CONTENT_LO +: 5] = poll_lv.content;
        status_word[`TSW_B_BUSY]    = poll_lv.busy;
        status_word[`TSW_B_REFMARK] = poll_lv.refmark;
        status_word[`TSW_B_WARNING] = poll_lv.warning;
      end
      default: status_word = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st   = st;
    wdat      = pwdata;
    wr_access = psel && penable && pwrite;
    rd_access = psel && !penable && !pwrite;
    too_early = trigger && (st.gap_cnt < st.min_gap);
    accepted  = trigger && !too_early;
    err_any   = |events;

    next_st.lv_meta = levels_async;
    next_st.lv_sync = st.lv_meta;

    if (st.tick_cnt + 32'h0000_0001 >= st.period) begin
      next_st.tick_cnt   = 32'h0000_0000;
      next_st.ts_counter = st.ts_counter + 32'h0000_0001;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
    end

    if (st.gap_cnt != 32'hFFFF_FFFF)
      next_st.gap_cnt = st.gap_cnt + 32'h0000_0001;

    if (accepted) begin
      next_st.timestamp  = st.ts_counter;
      next_st.gap_cnt    = 32'h0000_0000;
      next_st.accept_cnt = st.accept_cnt + 32'h0000_0001;
      next_st.lv_poll    = st.lv_sync;
    end
    next_st.packet.valid = accepted;
    if (accepted) begin
      next_st.packet.timestamp    = st.ts_enable ? st.ts_counter
                                                 : 32'h0000_0000;
      next_st.packet.status       = status_word;
      next_st.packet.accept_count = st.accept_cnt + 32'h0000_0001;
    end

    // apb: answer in the access cycle, zero wait
    next_st.pready  = psel && !penable;
    next_st.pslverr = 1'b0;
    if (rd_access) begin
      case (paddr)
        `TSW_OFF_CTRL:       next_st.prdata = {31'h0, st.ts_enable};
        `TSW_OFF_PERIOD:     next_st.prdata = st.period;
        `TSW_OFF_TICKS_US:   next_st.prdata = {16'h0000, TICKS_US};
        `TSW_OFF_MIN_GAP:    next_st.prdata = st.min_gap;
        `TSW_OFF_POLL_TYPE:  next_st.prdata = {30'h0, st.poll_type};
        `TSW_OFF_CLEAR:      next_st.prdata = 32'h0000_0000;
        `TSW_OFF_STATUS:     next_st.prdata = {16'h0000, status_word};
        `TSW_OFF_TIMESTAMP:  next_st.prdata = st.timestamp;
        `TSW_OFF_IRQ_STATUS: next_st.prdata = {29'h0, st.irq_status};
        `TSW_OFF_IRQ_MASK:   next_st.prdata = {29'h0, st.irq_mask};
        `TSW_OFF_ACCEPT_CNT: next_st.prdata = st.accept_cnt;
        default: begin
          next_st.prdata  = 32'h0000_0000;
          next_st.pslverr = 1'b1;
        end
      endcase
    end else if (psel && !penable) begin
      next_st.prdata = 32'h0000_0000;
      case (paddr)
        `TSW_OFF_CTRL, `TSW_OFF_PERIOD, `TSW_OFF_MIN_GAP,
        `TSW_OFF_POLL_TYPE, `TSW_OFF_CLEAR, `TSW_OFF_IRQ_STATUS,
        `TSW_OFF_IRQ_MASK: next_st.pslverr = 1'b0;
        default: next_st.pslverr = 1'b1;
      endcase
    end

    // writes take effect at the access edge; clears lose to new events
    if (wr_access) begin
      case (paddr)
        `TSW_OFF_CTRL:      next_st.ts_enable = wdat[0];
        `TSW_OFF_PERIOD:    next_st.period = (wdat == 32'h0) ? 32'h1 : wdat;
        `TSW_OFF_MIN_GAP:   next_st.min_gap = wdat;
        `TSW_OFF_POLL_TYPE: next_st.poll_type = tsw_poll_t'(wdat[1:0]);
        `TSW_OFF_CLEAR: begin
          next_st.sticky = st.sticky & ~tsw_events_t'(wdat[10:0]);
          if (wdat[11])
            next_st.lost = 1'b0;
        end
        `TSW_OFF_IRQ_STATUS:
          next_st.irq_status = st.irq_status & ~wdat[`TSW_IRQ_BITS-1:0];
        `TSW_OFF_IRQ_MASK:  next_st.irq_mask = wdat[`TSW_IRQ_BITS-1:0];
        default: next_st.ts_enable = st.ts_enable;
      endcase
    end

    next_st.sticky = next_st.sticky | events;
    if (too_early)
      next_st.lost = 1'b1;

    if (too_early)
      next_st.irq_status[`TSW_IRQ_LOST] = 1'b1;
    if (err_any)
      next_st.irq_status[`TSW_IRQ_ERROR] = 1'b1;
    if (accepted)
      next_st.irq_status[`TSW_IRQ_PACKET] = 1'b1;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st            <= '0;
      st.period     <= `TSW_PERIOD_RESET;
      st.min_gap    <= MIN_GAP_RESET;
      st.gap_cnt    <= 32'hFFFF_FFFF;
    end else begin
      st <= next_st;
    end
  end

  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign packet  = st.packet;
  assign irq     = st.irq;
endmodule

// file: rtl/tsw_consts.svh
/*
  constants for the trigger timestamp and status word block: register
  offsets, status bit positions, reset values and timing figures.
  assumes inclusion by bare name; definitions only.
*/
`ifndef TSW_CONSTS_SVH
`define TSW_CONSTS_SVH

`define TSW_OFF_CTRL        12'h000
`define TSW_OFF_PERIOD      12'h004
`define TSW_OFF_TICKS_US    12'h008
`define TSW_OFF_MIN_GAP     12'h00C
`define TSW_OFF_POLL_TYPE   12'h010
`define TSW_OFF_CLEAR       12'h014
`define TSW_OFF_STATUS      12'h018
`define TSW_OFF_TIMESTAMP   12'h01C
`define TSW_OFF_IRQ_STATUS  12'h020
`define TSW_OFF_IRQ_MASK    12'h024
`define TSW_OFF_ACCEPT_CNT  12'h028

`define TSW_CLK_MHZ         20
`define TSW_PERIOD_RESET    32'h0000_0014
`define TSW_MIN_GAP_NS      2000
`define TSW_MIN_GAP_CYCLES  ((`TSW_MIN_GAP_NS * `TSW_CLK_MHZ + 999) / 1000)

`define TSW_B_VALID         0
`define TSW_B_AMP_CRC       1
`define TSW_B_FREQ          3
`define TSW_B_POWER         4
`define TSW_B_FAN           5
`define TSW_B_LOST          7
`define TSW_B_REF1          8
`define TSW_B_REF2          9
`define TSW_B_CODED_OK      10
`define TSW_B_CODED_ERR     11
`define TSW_B_HOMING        12
`define TSW_B_LIMIT         13
`define TSW_B_CONTENT_LO    5
`define TSW_B_BUSY          10
`define TSW_B_REFMARK       11
`define TSW_B_WARNING       12

`define TSW_IRQ_LOST        0
`define TSW_IRQ_ERROR       1
`define TSW_IRQ_PACKET      2
`define TSW_IRQ_BITS        3

`endif

// file: rtl/tsw_pkg.sv
/*
  types of the trigger timestamp and status word block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package tsw_pkg;
  typedef enum logic [1:0] {
    TSW_POLL_INCR   = 2'b00,
    TSW_POLL_SERPOS = 2'b01,
    TSW_POLL_DATUM  = 2'b10,
    TSW_POLL_AUX    = 2'b11
  } tsw_poll_t;

  typedef struct packed {
    logic amp_low;
    logic crc_err;
    logic freq_exceeded;
    logic power_err;
    logic fan_err;
    logic ref1_saved;
    logic ref2_saved;
    logic coded_ok;
    logic coded_err;
    logic err_msg1;
    logic err_msg2;
  } tsw_events_t;

  typedef struct packed {
    logic       homing;
    logic       limit;
    logic       busy;
    logic       refmark;
    logic       warning;
    logic [4:0] content;
  } tsw_levels_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] timestamp;
    logic [15:0] status;
    logic [31:0] accept_count;
  } tsw_packet_t;

  typedef struct packed {
    logic [31:0] psel_addr_unused;
  } tsw_dummy_t;
endpackage
